// >>> hw/latch_pkg.sv
// Constants, register layout and state types of the set-reset latch unit.
package latch_pkg;

	// ----------------------------------------
	// Bus and register map
	// ----------------------------------------
	localparam int ADDR_W = 8;
	localparam int DATA_W = 32;
	localparam logic [ADDR_W-1:0] FIRST_OFS = 8'h00;
	localparam logic [ADDR_W-1:0] SECOND_OFS = 8'h04;

	// ----------------------------------------
	// Field positions of latch_control_first
	// ----------------------------------------
	localparam int F1_RESET_PULSE = 0;
	localparam int F1_SET_PULSE = 1;
	localparam int F1_LATCH_STATE = 2;
	localparam int F1_INV_EN = 3;
	localparam int F1_TRUE_EN = 4;
	localparam int F1_SEL_LSB = 5;
	localparam int SEL_W = 3;

	// ----------------------------------------
	// Field positions of latch_control_second
	// ----------------------------------------
	localparam int F2_RESET_CMP1 = 0;
	localparam int F2_RESET_CMP2 = 1;
	localparam int F2_RESET_EXT = 2;
	localparam int F2_RESET_CLK = 3;
	localparam int F2_SET_CMP1 = 4;
	localparam int F2_SET_CMP2 = 5;
	localparam int F2_SET_EXT = 6;
	localparam int F2_SET_CLK = 7;
	localparam int F2_SYNC_CMP1 = 8;
	localparam int CTL2_W = 10;

	// ----------------------------------------
	// Values after reset and counter sizes
	// ----------------------------------------
	localparam logic [SEL_W-1:0] SEL_RST = 3'h0;
	localparam logic [CTL2_W-1:0] CTL2_RST = 10'h000;
	localparam logic LATCH_RST = 1'b0;
	localparam int DIV_W = 8;
	localparam logic [DIV_W-1:0] DIV_RST = 8'h00;

	typedef struct packed {
		logic [SEL_W-1:0] period_sel;
		logic true_en;
		logic inv_en;
		logic set_pulse;
		logic reset_pulse;
		logic [CTL2_W-1:0] ctl2;
		logic [1:0] cmp_held;
		logic latch;
		logic [DATA_W-1:0] rdata;
	} unit_state_t;

endpackage

// >>> hw/period_tick.sv
// Free-running divider that gives a one-cycle tick every 2**(sel+1) clocks.
`timescale 1ns/1ps
module period_tick (
	input wire logic clk,
	input wire logic nrst,
	input wire logic [latch_pkg::SEL_W-1:0] sel,
	output logic tick
);
	import latch_pkg::*;

	typedef struct packed {
		logic [DIV_W-1:0] count;
		logic tick;
	} div_state_t;

	div_state_t st_reg;
	div_state_t st_next;
	logic [DIV_W-1:0] mask;

	always_comb begin
		mask = DIV_W'((9'h002 << sel) - 9'h001);
		st_next.count = st_reg.count + 8'h01;
		st_next.tick = ((st_reg.count & mask) == mask);
	end

	always_ff @(posedge clk or negedge nrst) begin
		if (!nrst) begin
			st_reg <= '{count: DIV_RST, tick: 1'b0};
		end else begin
			st_reg <= st_next;
		end
	end

	assign tick = st_reg.tick;
endmodule

// >>> hw/set_reset_latch_unit.sv
// Set-reset latch unit with APB registers, selectable sources and pin drivers.
//
// Overview of operation
// - Every set and reset source of the latch is active high.
// - When set and reset are high together the latch goes to the reset state.
// - Writing the software set bit sets the latch and the software reset bit resets it.
// - Both software bits clear themselves after one cycle, so one write completes the action.
// - Either comparator may drive set or reset, directly or held on the gated timer tick.
// - The external latch input pin may be chosen as a set source or a reset source.
// - An internal periodic tick with a three-bit period select can drive the latch.
// - Separate enables let the periodic tick set and reset the latch.
// - The true and inverted outputs have their own enables and may both be driven at once.
// - An output drives its pin only while that pin's direction bit is cleared.
// - No latch value is promised after reset.
`timescale 1ns/1ps
module set_reset_latch_unit (
	input wire logic clk,
	input wire logic nrst,
	input wire logic psel,
	input wire logic penable,
	input wire logic pwrite,
	input wire logic [latch_pkg::ADDR_W-1:0] paddr,
	input wire logic [latch_pkg::DATA_W-1:0] pwdata,
	output logic [latch_pkg::DATA_W-1:0] prdata,
	output logic pready,
	output logic pslverr,
	input wire logic cmp1_out,
	input wire logic cmp2_out,
	input wire logic ext_latch_input,
	input wire logic timer_tick,
	input wire logic q_pin_direction_bit,
	input wire logic nq_pin_direction_bit,
	output logic latch_q,
	output logic latch_q_oe_n,
	output logic latch_nq,
	output logic latch_nq_oe_n
);
	import latch_pkg::*;

	// ----------------------------------------
	// Address decoding
	// ----------------------------------------
	function automatic logic is_first(input logic [ADDR_W-1:0] a);
		return a == FIRST_OFS;
	endfunction

	function automatic logic is_second(input logic [ADDR_W-1:0] a);
		return a == SECOND_OFS;
	endfunction

	unit_state_t st_reg;
	unit_state_t st_next;
	logic [2:0] pins_sync;
	logic [1:0] cmp_sel;
	logic clk_tick;
	logic setup;
	logic wr;
	logic set_term;
	logic reset_term;
	logic [CTL2_W-1:0] c2;

	// ----------------------------------------
	// Source conditioning
	// ----------------------------------------
	// Comparators and the external pin come from outside this clock domain.
	sync2 #(.W(3)) u_sync (
		.clk(clk),
		.nrst(nrst),
		.async_in({ext_latch_input, cmp2_out, cmp1_out}),
		.sync_out(pins_sync)
	);

	period_tick u_tick (
		.clk(clk),
		.nrst(nrst),
		.sel(st_reg.period_sel),
		.tick(clk_tick)
	);

	// Each comparator is used either directly or in its timer-held form.
	genvar gi;
	generate
		for (gi = 0; gi < 2; gi++) begin : g_cmp
			assign cmp_sel[gi] = st_reg.ctl2[F2_SYNC_CMP1 + gi] ? st_reg.cmp_held[gi] : pins_sync[gi];
		end
	endgenerate

	assign c2 = st_reg.ctl2;

	// ----------------------------------------
	// Set and reset terms
	// ----------------------------------------
	// All sources are active high; each path ORs its enabled sources.
	always_comb begin
		set_term = st_reg.set_pulse
			| (cmp_sel[0] & c2[F2_SET_CMP1])
			| (cmp_sel[1] & c2[F2_SET_CMP2])
			| (pins_sync[2] & c2[F2_SET_EXT])
			| (clk_tick & c2[F2_SET_CLK]);
		reset_term = st_reg.reset_pulse
			| (cmp_sel[0] & c2[F2_RESET_CMP1])
			| (cmp_sel[1] & c2[F2_RESET_CMP2])
			| (pins_sync[2] & c2[F2_RESET_EXT])
			| (clk_tick & c2[F2_RESET_CLK]);
	end

	// ----------------------------------------
	// APB handshake
	// ----------------------------------------
	assign setup = psel & ~penable;
	assign wr = psel & penable & pwrite;
	assign pready = 1'b1;
	assign pslverr = psel & penable & ~is_first(paddr) & ~is_second(paddr);

	// ----------------------------------------
	// Next state
	// ----------------------------------------
	always_comb begin
		st_next = st_reg;
		// Software pulses live for one cycle; a new write wins over the self clear.
		st_next.set_pulse = 1'b0;
		st_next.reset_pulse = 1'b0;
		if (wr && is_first(paddr)) begin
			st_next.set_pulse = pwdata[F1_SET_PULSE];
			st_next.reset_pulse = pwdata[F1_RESET_PULSE];
			st_next.inv_en = pwdata[F1_INV_EN];
			st_next.true_en = pwdata[F1_TRUE_EN];
			st_next.period_sel = pwdata[F1_SEL_LSB +: SEL_W];
		end
		if (wr && is_second(paddr)) begin
			st_next.ctl2 = pwdata[CTL2_W-1:0];
		end
		if (timer_tick) begin
			st_next.cmp_held = pins_sync[1:0];
		end
		if (reset_term) begin
			st_next.latch = 1'b0;
		end else if (set_term) begin
			st_next.latch = 1'b1;
		end
		// Read data is captured in the setup phase and stands through the access phase.
		if (setup) begin
			st_next.rdata = '0;
			if (is_first(paddr)) begin
				st_next.rdata[F1_RESET_PULSE] = st_reg.reset_pulse;
				st_next.rdata[F1_SET_PULSE] = st_reg.set_pulse;
				st_next.rdata[F1_LATCH_STATE] = st_reg.latch;
				st_next.rdata[F1_INV_EN] = st_reg.inv_en;
				st_next.rdata[F1_TRUE_EN] = st_reg.true_en;
				st_next.rdata[F1_SEL_LSB +: SEL_W] = st_reg.period_sel;
			end else if (is_second(paddr)) begin
				st_next.rdata[CTL2_W-1:0] = st_reg.ctl2;
			end
		end
	end

	// ----------------------------------------
	// State register
	// ----------------------------------------
	// The latch value after reset is a fixed constant but carries no promise to firmware.
	always_ff @(posedge clk or negedge nrst) begin
		if (!nrst) begin
			st_reg <= '{period_sel: SEL_RST, true_en: 1'b0, inv_en: 1'b0, set_pulse: 1'b0,
				reset_pulse: 1'b0, ctl2: CTL2_RST, cmp_held: 2'b00, latch: LATCH_RST,
				rdata: '0};
		end else begin
			st_reg <= st_next;
		end
	end

	// ----------------------------------------
	// Outputs
	// ----------------------------------------
	// Firmware is expected to set or reset the latch before enabling the pins.
	assign prdata = st_reg.rdata;
	assign latch_q = st_reg.latch;
	assign latch_nq = ~st_reg.latch;
	assign latch_q_oe_n = ~(st_reg.true_en & ~q_pin_direction_bit);
	assign latch_nq_oe_n = ~(st_reg.inv_en & ~nq_pin_direction_bit);

	// ----------------------------------------
	// Assertions
	// ----------------------------------------
	default clocking cb @(posedge clk);
	endclocking
	default disable iff (!nrst);

	reset_dominant_a: assert property (set_term && reset_term |=> !latch_q)
		else $error("Latch not reset when set and reset were both high.");

	set_path_a: assert property (set_term && !reset_term |=> latch_q)
		else $error("Latch not set by an active set term.");

	reset_path_a: assert property (reset_term |=> latch_q == 1'b0)
		else $error("Latch not reset by an active reset term.");

	hold_a: assert property (!set_term && !reset_term |=> $stable(latch_q))
		else $error("Latch changed with no active source.");

	sw_set_write_a: assert property (wr && is_first(paddr) && pwdata[F1_SET_PULSE]
		|=> st_reg.set_pulse ##1 (latch_q || $past(reset_term)))
		else $error("Software set write did not set the latch.");

	pulse_clear_a: assert property (st_reg.set_pulse && !(wr && is_first(paddr))
		|=> !st_reg.set_pulse)
		else $error("Software set bit did not clear itself.");

	reset_clear_a: assert property (st_reg.reset_pulse && !(wr && is_first(paddr))
		|=> !st_reg.reset_pulse)
		else $error("Software reset bit did not clear itself.");

	timer_hold_a: assert property (!timer_tick |=> $stable(st_reg.cmp_held))
		else $error("Held comparator value changed without a timer tick.");

	ext_set_a: assert property (pins_sync[2] && c2[F2_SET_EXT] && !reset_term |=> latch_q)
		else $error("External input did not set the latch.");

	clock_reset_a: assert property (clk_tick && c2[F2_RESET_CLK] |=> !latch_q)
		else $error("Periodic tick did not reset the latch.");

	pin_drive_a: assert property (!latch_q_oe_n |-> st_reg.true_en && !q_pin_direction_bit)
		else $error("True output driven without enable or with pin as input.");

	outputs_pair_a: assert property (latch_nq == !latch_q)
		else $error("Inverted output does not mirror the true output.");

	read_first_a: assert property (setup && is_first(paddr)
		|=> prdata[F1_LATCH_STATE] == $past(st_reg.latch))
		else $error("Read of the first control register returned wrong latch state.");

	// Every source path except the software pulses reaches the latch through its own enable.
	ext_reset_a: assert property (pins_sync[2] && c2[F2_RESET_EXT] |=> !latch_q)
		else $error("External input did not reset the latch.");

	clock_set_a: assert property (clk_tick && c2[F2_SET_CLK] && !reset_term |=> latch_q)
		else $error("Periodic tick did not set the latch.");

	cmp1_set_a: assert property (cmp_sel[0] && c2[F2_SET_CMP1] && !reset_term |=> latch_q)
		else $error("Comparator one did not set the latch.");

	cmp2_set_a: assert property (cmp_sel[1] && c2[F2_SET_CMP2] && !reset_term |=> latch_q)
		else $error("Comparator two did not set the latch.");

	cmp1_reset_a: assert property (cmp_sel[0] && c2[F2_RESET_CMP1] |=> !latch_q)
		else $error("Comparator one did not reset the latch.");

	cmp2_reset_a: assert property (cmp_sel[1] && c2[F2_RESET_CMP2] |=> !latch_q)
		else $error("Comparator two did not reset the latch.");

	held_select_a: assert property (c2[F2_SYNC_CMP1] |-> cmp_sel[0] == st_reg.cmp_held[0])
		else $error("Comparator one does not use its held form.");

	direct_select_a: assert property (!c2[F2_SYNC_CMP1 + 1] |-> cmp_sel[1] == pins_sync[1])
		else $error("Comparator two does not use its direct form.");

	held_capture_a: assert property (timer_tick |=> st_reg.cmp_held == $past(pins_sync[1:0]))
		else $error("Held comparator values not captured on the timer tick.");

	tick_spacing_a: assert property (clk_tick |=> !clk_tick)
		else $error("Periodic tick lasted more than one cycle.");

	sw_reset_write_a: assert property (wr && is_first(paddr) && pwdata[F1_RESET_PULSE]
		|=> st_reg.reset_pulse ##1 !latch_q)
		else $error("Software reset write did not reset the latch.");

	// Register writes and reads.
	ctl2_write_a: assert property (wr && is_second(paddr) |=> st_reg.ctl2 == $past(pwdata[CTL2_W-1:0]))
		else $error("Source enables not stored by a write.");

	period_write_a: assert property (wr && is_first(paddr)
		|=> st_reg.period_sel == $past(pwdata[F1_SEL_LSB +: SEL_W]))
		else $error("Period select not stored by a write.");

	enable_write_a: assert property (wr && is_first(paddr)
		|=> st_reg.true_en == $past(pwdata[F1_TRUE_EN]) && st_reg.inv_en == $past(pwdata[F1_INV_EN]))
		else $error("Output enables not stored by a write.");

	read_second_a: assert property (setup && is_second(paddr)
		|=> prdata[CTL2_W-1:0] == $past(st_reg.ctl2))
		else $error("Read of the second control register returned wrong enables.");

	// Pin drivers.
	nq_drive_a: assert property (!latch_nq_oe_n |-> st_reg.inv_en && !nq_pin_direction_bit)
		else $error("Inverted output driven without enable or with pin as input.");

	both_pins_a: assert property (st_reg.true_en && st_reg.inv_en && !q_pin_direction_bit
		&& !nq_pin_direction_bit |-> !latch_q_oe_n && !latch_nq_oe_n)
		else $error("Both outputs enabled but not both driven.");

	true_off_a: assert property (!st_reg.true_en |-> latch_q_oe_n)
		else $error("True output driven while disabled.");

	inv_off_a: assert property (!st_reg.inv_en |-> latch_nq_oe_n)
		else $error("Inverted output driven while disabled.");

	q_input_a: assert property (q_pin_direction_bit |-> latch_q_oe_n)
		else $error("True output driven while its pin is an input.");

	nq_input_a: assert property (nq_pin_direction_bit |-> latch_nq_oe_n)
		else $error("Inverted output driven while its pin is an input.");

	both_driven_c: cover property (!latch_q_oe_n && !latch_nq_oe_n);
	sw_set_c: cover property (wr && is_first(paddr) && pwdata[F1_SET_PULSE] ##2 latch_q);
	conflict_c: cover property (set_term && reset_term);
	clock_set_c: cover property (clk_tick && c2[F2_SET_CLK] ##1 latch_q);
	held_set_c: cover property (timer_tick && c2[F2_SYNC_CMP1] ##1 cmp_sel[0]);
endmodule

// >>> hw/sync2.sv
// Two-stage synchroniser for asynchronous level inputs.
`timescale 1ns/1ps
module sync2 #(
	parameter int W = 3
) (
	input wire logic clk,
	input wire logic nrst,
	input wire logic [W-1:0] async_in,
	output logic [W-1:0] sync_out
);
	typedef struct packed {
		logic [W-1:0] first;
		logic [W-1:0] second;
	} sync_state_t;

	sync_state_t st_reg;
	sync_state_t st_next;

	always_comb begin
		st_next.first = async_in;
		st_next.second = st_reg.first;
	end

	always_ff @(posedge clk or negedge nrst) begin
		if (!nrst) begin
			st_reg <= '0;
		end else begin
			st_reg <= st_next;
		end
	end

	assign sync_out = st_reg.second;
endmodule

// >>> testbench/far_side_model.sv
// Model of the comparators, the external input pin and the gated timer.
`timescale 1ns/1ps
module far_side_model (
	input wire logic clk,
	input wire logic nrst,
	input wire logic [1:0] cmp_level,
	input wire logic ext_level,
	input wire logic tick_run,
	output logic cmp1_out,
	output logic cmp2_out,
	output logic ext_latch_input,
	output logic timer_tick
);
	logic [2:0] cnt;
	// ----------------------------------------
	// Sources and timer
	// ----------------------------------------
	// Comparator and pin levels are presented active high.
	assign cmp1_out = cmp_level[0];
	assign cmp2_out = cmp_level[1];
	assign ext_latch_input = ext_level;
	// The gated timer ticks once every eight clocks while it runs.
	always_ff @(posedge clk or negedge nrst) begin
		if (!nrst) begin
			cnt <= 3'h0;
		end else if (tick_run) begin
			cnt <= cnt + 3'h1;
		end
	end
	assign timer_tick = tick_run && (cnt == 3'h7);
endmodule

// >>> testbench/tb_top.sv
// Self-checking testbench of the set-reset latch unit.
`timescale 1ns/1ps
module tb_top;
	import latch_pkg::*;
	logic clk = 1'b0;
	logic nrst = 1'b0;
	logic psel = 1'b0;
	logic penable = 1'b0;
	logic pwrite = 1'b0;
	logic [ADDR_W-1:0] paddr = 8'h00;
	logic [DATA_W-1:0] pwdata = 32'h0;
	logic [1:0] cmp_level = 2'h0;
	logic ext_level = 1'b0;
	logic tick_run = 1'b0;
	logic dir_q = 1'b1;
	logic dir_nq = 1'b1;
	logic [DATA_W-1:0] prdata, rd;
	logic pready, pslverr, err, cmp1, cmp2, ext, tick, q, q_oe_n, nq, nq_oe_n;
	int err_count = 0;
	int n_compared = 0;
	int n;
	always #5 clk = ~clk;
	set_reset_latch_unit uut (.clk(clk), .nrst(nrst), .psel(psel), .penable(penable), .pwrite(pwrite),
		.paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr), .cmp1_out(cmp1),
		.cmp2_out(cmp2), .ext_latch_input(ext), .timer_tick(tick), .q_pin_direction_bit(dir_q),
		.nq_pin_direction_bit(dir_nq), .latch_q(q), .latch_q_oe_n(q_oe_n), .latch_nq(nq), .latch_nq_oe_n(nq_oe_n));
	far_side_model far (.clk(clk), .nrst(nrst), .cmp_level(cmp_level), .ext_level(ext_level), .tick_run(tick_run),
		.cmp1_out(cmp1), .cmp2_out(cmp2), .ext_latch_input(ext), .timer_tick(tick));
	// ----------------------------------------
	// Bus and check tasks
	// ----------------------------------------
	task automatic apb(input logic wr, input logic [ADDR_W-1:0] a, input logic [DATA_W-1:0] d);
		int k;
		@(posedge clk);
		psel <= 1'b1;
		pwrite <= wr;
		paddr <= a;
		pwdata <= d;
		@(posedge clk);
		penable <= 1'b1;
		k = 0;
		do begin
			@(posedge clk);
			k++;
		end while (pready !== 1'b1 && k < 50);
		if (pready !== 1'b1) begin
			err_count++;
			$display("mismatch pready expected 1 seen %b", pready);
		end
		rd = prdata;
		err = pslverr;
		psel <= 1'b0;
		penable <= 1'b0;
	endtask
	task automatic cyc(input int c);
		repeat (c) @(posedge clk);
		#1;
	endtask
	task automatic drive(input int i, input logic v);
		@(posedge clk);
		if (i < 2) begin
			cmp_level[i] <= v;
		end else begin
			ext_level <= v;
		end
	endtask
	task automatic chk(input string what, input logic [DATA_W-1:0] exp, input logic [DATA_W-1:0] got);
		n_compared++;
		if (got !== exp) begin
			err_count++;
			$display("mismatch %s expected %h seen %h", what, exp, got);
		end
	endtask
	task automatic tally_and_finish;
		if (err_count == 0 && n_compared > 0) begin
			$display("STATUS OK");
		end else begin
			$display("STATUS NOT OK");
		end
		$finish;
	endtask
	// ----------------------------------------
	// Test sequence
	// ----------------------------------------
	initial begin
		repeat (16) @(posedge clk);
		nrst <= 1'b1;
		apb(1, FIRST_OFS, 32'h2);
		cyc(2);
		chk("q after set pulse", 1, q);
		chk("nq after set pulse", 0, nq);
		apb(0, FIRST_OFS, 0);
		chk("first readback", 32'h4, rd);
		apb(1, FIRST_OFS, 32'h1);
		cyc(2);
		chk("q after reset pulse", 0, q);
		apb(1, FIRST_OFS, 32'h2);
		apb(1, FIRST_OFS, 32'h3);
		cyc(2);
		chk("q after both pulses", 0, q);
		for (int i = 0; i < 3; i++) begin
			apb(1, SECOND_OFS, 32'h10 << i);
			cyc(5);
			chk("q with source low", 0, q);
			drive(i, 1'b1);
			cyc(5);
			chk("q by source set", 1, q);
			drive(i, 1'b0);
			apb(1, SECOND_OFS, 32'h11 << i);
			drive(i, 1'b1);
			cyc(5);
			chk("q by source reset", 0, q);
			drive(i, 1'b0);
		end
		for (int i = 0; i < 2; i++) begin
			apb(1, SECOND_OFS, (32'h10 << i) | (32'h100 << i));
			drive(i, 1'b1);
			cyc(10);
			chk("held form without tick", 0, q);
			@(posedge clk);
			tick_run <= 1'b1;
			cyc(16);
			chk("held form after tick", 1, q);
			drive(i, 1'b0);
			cyc(16);
			@(posedge clk);
			tick_run <= 1'b0;
			apb(1, FIRST_OFS, 32'h1);
		end
		for (int s = 0; s < 8; s += 7) begin
			apb(1, SECOND_OFS, 0);
			apb(1, FIRST_OFS, (s << 5) | 1);
			apb(0, FIRST_OFS, 0);
			chk("period select readback", s << 5, rd & 32'he0);
			apb(1, SECOND_OFS, 32'h80);
			n = 0;
			while (q !== 1'b1 && n < 300) begin
				cyc(1);
				n++;
			end
			chk("q by clock set", 1, q);
			chk("clock set within period", 1, n <= (2 ** (s + 1)) + 4);
			apb(1, SECOND_OFS, 32'h88);
			cyc(300);
			chk("q by clock reset", 0, q);
		end
		apb(0, 8'h08, 0);
		chk("unmapped error", 1, err);
		chk("unmapped data", 0, rd);
		apb(1, 8'h08, 32'hff);
		apb(0, SECOND_OFS, 0);
		chk("second kept", 32'h88, rd);
		chk("mapped error", 0, err);
		apb(1, SECOND_OFS, 0);
		apb(1, FIRST_OFS, 32'h2);
		apb(1, FIRST_OFS, 32'h18);
		for (int d = 0; d < 4; d++) begin
			@(posedge clk);
			dir_q <= d[0];
			dir_nq <= d[1];
			cyc(2);
			chk("true oe", d[0], q_oe_n);
			chk("inverted oe", d[1], nq_oe_n);
		end
		apb(1, FIRST_OFS, 32'h10);
		cyc(2);
		chk("inverted oe off", 1, nq_oe_n);
		chk("q held", 1, q);
		tally_and_finish;
	end
	initial begin
		#400000;
		err_count++;
		tally_and_finish;
	end
endmodule
